/* fac_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fac_host (
  input  wire logic        clk_sys,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata
);
  import fac_pkg::*;
  initial begin
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
  end
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    q = 32'h0;
    if (wr && a == A_DADDR && d[6:1] == 6'h2d) return;
    if (wr && a == A_RETRY && (d <= 32'h78 || d > 32'h147a8)) return;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
endmodule : fac_host
`default_nettype wire

/* fac_pkg.sv */
package fac_pkg;
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_GCFG   = 8'h08;
  localparam logic [7:0] A_DADDR  = 8'h0c;
  localparam logic [7:0] A_VOUT0  = 8'h10;
  localparam logic [7:0] A_VOUT1  = 8'h14;
  localparam logic [7:0] A_FREQ   = 8'h18;
  localparam logic [7:0] A_RETRY  = 8'h1c;
  localparam logic [7:0] A_FMAP   = 8'h20;
  localparam logic [7:0] A_RESP   = 8'h24;
  localparam logic [7:0] A_MASK   = 8'h28;
  localparam logic [7:0] A_STAT   = 8'h2c;
  localparam logic [7:0] A_SWORD  = 8'h30;
  localparam logic [7:0] A_PINS   = 8'h34;
  localparam logic [7:0] A_COMMON = 8'h38;
  localparam logic [7:0] A_SADDR  = 8'h3c;
  localparam int CMD_CLR     = 0;
  localparam int CMD_RST     = 1;
  localparam int CMD_RESTORE = 2;
  localparam int CMD_ARA     = 3;
  localparam int GCFG_IGNORE = 6;
  localparam int GCFG_SYNCX  = 4;
  localparam int PINS_ISYNC  = 10;
  localparam int ST_PLL      = 16;
  localparam int ST_CML      = 17;
  localparam int ST_BUSY     = 18;
  localparam logic [7:0]  GCFG_RST  = 8'h00;
  localparam logic [6:0]  DADDR_RST = 7'h30;
  localparam logic [11:0] VOUT_RST  = 12'h000;
  localparam logic [3:0]  FREQ_RST  = 4'h0;
  localparam logic [16:0] RETRY_RST = 17'h000c8;
  localparam logic [1:0]  SMP_DLY   = 2'h3;
  localparam logic [10:0] PM_OV_F = 11'h44c;
  localparam logic [10:0] PM_OV_W = 11'h433;
  localparam logic [10:0] PM_MH   = 11'h41a;
  localparam logic [10:0] PM_ML   = 11'h3b6;
  localparam logic [10:0] PM_UV_W = 11'h3a7;
  localparam logic [10:0] PM_UV_F = 11'h3a2;
  localparam int CLK_NS      = 4;
  localparam int MS_NS       = 1000000;
  localparam int SYNC_WIN_NS = 400;
  localparam int SYNC_WIN_CYC = SYNC_WIN_NS / CLK_NS;
  typedef struct packed {logic flt; logic [3:0] code;} fac_pin_s;
  typedef struct packed {
    logic ot_f; logic oc_w; logic oc_f; logic uv_f; logic uv_w; logic ov_w; logic ov_f;
  } fac_evt_s;
  typedef struct packed {
    logic [11:0] ov_f; logic [11:0] ov_w; logic [11:0] vmax; logic [11:0] mh;
    logic [11:0] ml; logic [11:0] uv_w; logic [11:0] uv_f;
  } fac_lim_s;
  typedef enum logic [3:0] {
    REC_OFF = 4'b0001, REC_ON = 4'b0010, REC_LATCH = 4'b0100, REC_RETRY = 4'b1000
  } fac_rec_e;
endpackage : fac_pkg

/* fac_top.sv */
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fac_top #(
  parameter int          MS_CYC    = fac_pkg::MS_NS / fac_pkg::CLK_NS,
  parameter int          SYNC_HALF = 10,
  parameter logic [11:0] VBASE     = 12'h100,
  parameter logic [11:0] VSTEP     = 12'h020
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire fac_pkg::fac_pin_s   addr_low_select_pin,
  input  wire fac_pkg::fac_pin_s   addr_high_select_pin,
  input  wire fac_pkg::fac_pin_s   freq_select_pin,
  input  wire fac_pkg::fac_pin_s   ch0_voltage_select_pin,
  input  wire fac_pkg::fac_pin_s   ch1_voltage_select_pin,
  input  wire fac_pkg::fac_evt_s [1:0] ch_evt,
  input  wire logic [1:0]          fault_cond,
  input  wire logic                sync_i,
  output logic                     sync_o,
  output logic                     sync_oe,
  input  wire logic [1:0]          fault_line_i,
  output logic [1:0]               fault_line_o,
  output logic [1:0]               fault_line_oe,
  output logic                     alert_n,
  output logic [6:0]               slave_addr,
  output logic [3:0]               freq_sel,
  output logic [1:0]               ch_run,
  output logic [1:0]               ch_ss_start,
  output logic [1:0][11:0]         ch_setpoint,
  output fac_pkg::fac_lim_s [1:0]  ch_limits
);
  import fac_pkg::*;
  localparam int PW = $clog2(MS_CYC + 1);

  function automatic logic [11:0] pct(input logic [11:0] v, input logic [10:0] pm);
    logic [22:0] p;
    p = 23'(v) * 23'(pm);
    return 12'(p / 23'd1000);
  endfunction : pct

  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_val;
  logic [31:0] wm;
  logic [31:0] bemask;
  logic        wr_go;
  logic        rd_go;
  logic        mapped;
  assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wm     = (rd_val & ~bemask) | (avs_writedata & bemask);
  // Write lands on the edge where waitrequest is seen low
  assign wr_go  = avs_write & ~wait_ff;
  assign rd_go  = avs_read & wait_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff <= ~((avs_read | avs_write) & wait_ff);
      if (rd_go) begin
        rdata_ff <= rd_val;
      end
    end
  end
  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  // Config pins come from outside: two flops first
  fac_pin_s [4:0] pin_s1_ff;
  fac_pin_s [4:0] pin_s;
  always_ff @(posedge clk_sys) begin
    pin_s1_ff <= {ch1_voltage_select_pin, ch0_voltage_select_pin, freq_select_pin,
                  addr_high_select_pin, addr_low_select_pin};
    pin_s     <= pin_s1_ff;
  end

  logic [1:0]  on_ff;
  logic [1:0]  on_q_ff;
  logic [7:0]  gcfg_ff;
  logic [6:0]  daddr_ff;
  logic [11:0] vout_ff [2];
  logic [3:0]  freq_ff;
  logic [16:0] retry_ff;
  logic [15:0] fmap_ff;
  logic [1:0]  resp_ff;
  logic [17:0] mask_ff;
  logic [6:0]  saddr_ff;
  logic [1:0]  smp_cnt_ff;
  logic        smp;
  logic [4:0]  use_pin;
  logic        cmd_wr;
  logic        unsafe;
  logic        busy_set;
  assign cmd_wr   = wr_go && avs_address == A_CMD;
  assign unsafe   = wr_go && |on_ff &&
                    (avs_address == A_GCFG || avs_address == A_DADDR || avs_address == A_FREQ);
  assign busy_set = unsafe;
  assign smp      = smp_cnt_ff == 2'h1;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      smp_cnt_ff <= SMP_DLY;
    end else if (cmd_wr && (wm[CMD_RST] || wm[CMD_RESTORE])) begin
      smp_cnt_ff <= SMP_DLY;
    end else if (smp_cnt_ff != 2'h0) begin
      smp_cnt_ff <= smp_cnt_ff - 2'h1;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_use
      if (k < 2) begin : g_a
        assign use_pin[k] = !pin_s[k].flt;
      end else begin : g_c
        assign use_pin[k] = !pin_s[k].flt && !gcfg_ff[GCFG_IGNORE];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      saddr_ff <= DADDR_RST;
    end else if (smp) begin
      saddr_ff[6:4] <= use_pin[1] ? pin_s[1].code[2:0] : daddr_ff[6:4];
      saddr_ff[3:0] <= use_pin[0] ? pin_s[0].code : daddr_ff[3:0];
    end
  end
  assign slave_addr = saddr_ff;

  // Stored registers; bus writes win over pin values afterwards
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      gcfg_ff  <= GCFG_RST;
      daddr_ff <= DADDR_RST;
      freq_ff  <= FREQ_RST;
      retry_ff <= RETRY_RST;
      fmap_ff  <= 16'h0;
      resp_ff  <= 2'h0;
      mask_ff  <= 18'h0;
    end else if (smp) begin
      if (use_pin[2]) begin
        freq_ff <= pin_s[2].code;
      end
    end else if (wr_go && !unsafe) begin
      unique case (avs_address)
        A_GCFG:  gcfg_ff  <= wm[7:0];
        A_DADDR: daddr_ff <= wm[6:0];
        A_FREQ:  freq_ff  <= wm[3:0];
        A_RETRY: retry_ff <= wm[16:0];
        A_FMAP:  fmap_ff  <= wm[15:0];
        A_RESP:  resp_ff  <= wm[1:0];
        A_MASK:  mask_ff  <= wm[17:0];
        default: ;
      endcase
    end
  end
  assign freq_sel = freq_ff;

  generate
    for (k = 0; k < 2; k++) begin : g_vo
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          vout_ff[k]   <= VOUT_RST;
          ch_limits[k] <= '0;
          on_ff[k]     <= 1'b0;
        end else if (smp) begin
          on_ff[k] <= use_pin[3+k];
          if (use_pin[3+k]) begin
            vout_ff[k] <= 12'(VBASE + 12'(pin_s[3+k].code * VSTEP));
            ch_limits[k].ov_f <= pct(12'(VBASE + 12'(pin_s[3+k].code * VSTEP)), PM_OV_F);
            ch_limits[k].ov_w <= pct(12'(VBASE + 12'(pin_s[3+k].code * VSTEP)), PM_OV_W);
            ch_limits[k].vmax <= pct(12'(VBASE + 12'(pin_s[3+k].code * VSTEP)), PM_OV_W);
            ch_limits[k].mh   <= pct(12'(VBASE + 12'(pin_s[3+k].code * VSTEP)), PM_MH);
            ch_limits[k].ml   <= pct(12'(VBASE + 12'(pin_s[3+k].code * VSTEP)), PM_ML);
            ch_limits[k].uv_w <= pct(12'(VBASE + 12'(pin_s[3+k].code * VSTEP)), PM_UV_W);
            ch_limits[k].uv_f <= pct(12'(VBASE + 12'(pin_s[3+k].code * VSTEP)), PM_UV_F);
          end
        end else if (wr_go && avs_address == A_CTRL) begin
          on_ff[k] <= wm[k];
        end else if (wr_go && avs_address == (k == 0 ? A_VOUT0 : A_VOUT1)) begin
          vout_ff[k] <= wm[11:0];
        end
      end
      assign ch_setpoint[k] = vout_ff[k];
    end
  endgenerate

  // External sync: edges seen only while not driving ourselves
  logic       sy_s1_ff;
  logic       sy_s2_ff;
  logic       sy_s3_ff;
  logic [7:0] sy_cnt_ff;
  logic [7:0] div_ff;
  logic       ext_pres;
  assign ext_pres = sy_cnt_ff < 8'(SYNC_WIN_CYC);
  always_ff @(posedge clk_sys) begin
    sy_s1_ff <= sync_i;
    sy_s2_ff <= sy_s1_ff;
    sy_s3_ff <= sy_s2_ff;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sy_cnt_ff <= 8'(SYNC_WIN_CYC);
      sync_oe   <= 1'b0;
      sync_o    <= 1'b0;
      div_ff    <= 8'h0;
    end else begin
      if ((sy_s2_ff ^ sy_s3_ff) && !sync_oe) begin
        sy_cnt_ff <= 8'h0;
      end else if (ext_pres) begin
        sy_cnt_ff <= sy_cnt_ff + 8'h1;
      end
      sync_oe <= !gcfg_ff[GCFG_SYNCX] && !ext_pres;
      if (div_ff == 8'(SYNC_HALF - 1)) begin
        div_ff <= 8'h0;
        sync_o <= ~sync_o;
      end else begin
        div_ff <= div_ff + 8'h1;
      end
    end
  end

  // Fault lines: input side synchronised, own drive masked with its echo
  logic [1:0] fl_s1_ff;
  logic [1:0] fl_s2_ff;
  logic [1:0] oe_d1_ff;
  logic [1:0] oe_d2_ff;
  logic [1:0] ext_ev;
  always_ff @(posedge clk_sys) begin
    fl_s1_ff <= fault_line_i;
    fl_s2_ff <= fl_s1_ff;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      oe_d1_ff     <= 2'h0;
      oe_d2_ff     <= 2'h0;
      fault_line_o <= 2'h0;
    end else begin
      oe_d1_ff     <= fault_line_oe;
      oe_d2_ff     <= oe_d1_ff;
      fault_line_o <= 2'h0;
    end
  end
  assign ext_ev = ~fl_s2_ff & ~fault_line_oe & ~oe_d1_ff & ~oe_d2_ff;

  // Status and alert
  logic [7:0]  stat_ff [2];
  logic        pll_ff;
  logic        cml_ff;
  logic        busy_ff;
  logic        ara_q_ff;
  logic        pll_ev;
  logic        cml_ev;
  logic        clr_all;
  logic [7:0]  set_ch [2];
  logic [1:0]  ch_pend;
  logic [1:0]  ch_new;
  logic        pend;
  logic        new_ev;
  logic [15:0] sw [2];
  assign pll_ev  = freq_ff == 4'h0 && !ext_pres && smp_cnt_ff == 2'h0;
  assign cml_ev  = (wr_go || rd_go) && !mapped;
  assign clr_all = cmd_wr && (wm[CMD_CLR] || wm[CMD_RST]);
  generate
    for (k = 0; k < 2; k++) begin : g_st
      assign set_ch[k]  = {ext_ev[k], ch_evt[k]};
      assign ch_pend[k] = |(stat_ff[k] & ~mask_ff[8*k+:8]);
      assign ch_new[k]  = |(set_ch[k] & ~mask_ff[8*k+:8]);
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          stat_ff[k] <= 8'h0;
        end else begin
          // Set wins over any clear in the same cycle
          stat_ff[k] <= (stat_ff[k] & ~((clr_all || (on_ff[k] && !on_q_ff[k])) ? 8'hff :
                        ((wr_go && avs_address == A_STAT) ? wm[8*k+:8] & bemask[8*k+:8] : 8'h0)))
                        | set_ch[k];
        end
      end
      assign sw[k] = {|stat_ff[k][3:0], |stat_ff[k][5:4], 1'b0, 1'b0,
                      stat_ff[k][7] | pll_ff, 3'h0, busy_ff, !ch_run[k], 3'h0,
                      stat_ff[k][6], cml_ff, |stat_ff[k][5:0]};
    end
  endgenerate

  logic [2:0] c_clr;
  assign c_clr = clr_all ? 3'h7 : (wr_go && avs_address == A_STAT) ?
                 (avs_writedata[ST_BUSY:ST_PLL] & {3{avs_byteenable[2]}}) : 3'h0;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pll_ff  <= 1'b0;
      cml_ff  <= 1'b0;
      busy_ff <= 1'b0;
      on_q_ff <= 2'h0;
    end else begin
      pll_ff  <= (pll_ff & ~c_clr[0]) | pll_ev;
      cml_ff  <= (cml_ff & ~c_clr[1]) | cml_ev;
      busy_ff <= (busy_ff & ~c_clr[2]) | busy_set;
      on_q_ff <= on_ff;
    end
  end

  // Pin-state is left out of both terms; common status enters both, busy without a mask
  assign pend   = |ch_pend | (pll_ff & ~mask_ff[ST_PLL]) | (cml_ff & ~mask_ff[ST_CML]) | busy_ff;
  assign new_ev = |ch_new | (pll_ev & ~mask_ff[ST_PLL]) | (cml_ev & ~mask_ff[ST_CML]) | busy_set;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ara_q_ff <= 1'b0;
      alert_n  <= 1'b1;
    end else begin
      if (new_ev) begin
        ara_q_ff <= 1'b0;
      end else if (cmd_wr && wm[CMD_ARA]) begin
        ara_q_ff <= 1'b1;
      end
      alert_n <= !(pend && !ara_q_ff);
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0;
    unique case (avs_address)
      A_CTRL:   rd_val = {30'h0, on_ff};
      A_CMD:    rd_val = 32'h0;
      A_GCFG:   rd_val = {24'h0, gcfg_ff};
      A_DADDR:  rd_val = {25'h0, daddr_ff};
      A_VOUT0:  rd_val = {20'h0, vout_ff[0]};
      A_VOUT1:  rd_val = {20'h0, vout_ff[1]};
      A_FREQ:   rd_val = {28'h0, freq_ff};
      A_RETRY:  rd_val = {15'h0, retry_ff};
      A_FMAP:   rd_val = {16'h0, fmap_ff};
      A_RESP:   rd_val = {30'h0, resp_ff};
      A_MASK:   rd_val = {14'h0, mask_ff};
      A_STAT:   rd_val = {13'h0, busy_ff, cml_ff, pll_ff, stat_ff[1], stat_ff[0]};
      A_SWORD:  rd_val = {sw[1], sw[0]};
      A_PINS:   rd_val = {21'h0, sync_oe && !gcfg_ff[GCFG_SYNCX], 5'h0,
                          pin_s[4].flt, pin_s[3].flt, pin_s[2].flt, pin_s[1].flt, pin_s[0].flt};
      A_COMMON: rd_val = {27'h0, busy_ff, ext_pres, ch_run, |on_ff};
      A_SADDR:  rd_val = {25'h0, saddr_ff};
      default:  mapped = 1'b0;
    endcase
  end

  // Recovery per channel
  generate
    for (k = 0; k < 2; k++) begin : g_rec
      fac_rec_e    st_ff;
      logic [7:0]  cause_ff;
      logic [PW-1:0] pre_ff;
      logic [16:0] ms_ff;
      logic        hit;
      logic        due;
      assign hit = ch_evt[k].ov_f | ch_evt[k].uv_f | ch_evt[k].oc_f | ch_evt[k].ot_f | ext_ev[k];
      assign due = ms_ff >= retry_ff;
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          st_ff          <= REC_OFF;
          cause_ff       <= 8'h0;
          ch_ss_start[k] <= 1'b0;
        end else begin
          ch_ss_start[k] <= 1'b0;
          unique case (st_ff)
            REC_OFF: if (on_ff[k]) begin
              st_ff          <= REC_ON;
              ch_ss_start[k] <= 1'b1;
            end
            REC_ON: if (!on_ff[k]) begin
              st_ff <= REC_OFF;
            end else if (hit) begin
              st_ff    <= resp_ff[k] ? REC_RETRY : REC_LATCH;
              cause_ff <= set_ch[k];
            end
            REC_LATCH: if (!on_ff[k]) begin
              st_ff    <= REC_OFF;
              cause_ff <= 8'h0;
            end
            REC_RETRY: if (!on_ff[k]) begin
              st_ff    <= REC_OFF;
              cause_ff <= 8'h0;
            end else if (due && !fault_cond[k] && !ext_ev[k]) begin
              st_ff          <= REC_ON;
              cause_ff       <= 8'h0;
              ch_ss_start[k] <= 1'b1;
            end
            default: st_ff <= REC_OFF;
          endcase
        end
      end
      // Interval restarts while the fault persists
      always_ff @(posedge clk_sys) begin
        if (!rst_b || st_ff != REC_RETRY || due) begin
          pre_ff <= '0;
          ms_ff  <= 17'h0;
        end else if (pre_ff == PW'(MS_CYC - 1)) begin
          pre_ff <= '0;
          ms_ff  <= ms_ff + 17'h1;
        end else begin
          pre_ff <= pre_ff + PW'(1);
        end
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          fault_line_oe[k] <= 1'b0;
          ch_run[k]        <= 1'b0;
        end else begin
          fault_line_oe[k] <= st_ff != REC_ON && |(cause_ff & fmap_ff[8*k+:8]);
          ch_run[k]        <= st_ff == REC_ON;
        end
      end

      AST_LATCH: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff == REC_ON && on_ff[k] && hit && !resp_ff[k] |=> st_ff == REC_LATCH)
        else $error("latched response not taken");
      AST_FLINE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        fault_line_oe[k] |-> $past(|(cause_ff & fmap_ff[8*k+:8])))
        else $error("fault line driven for unmapped fault");
    end
  endgenerate

  AST_ADDR_HI: assert property (@(posedge clk_sys) disable iff (!rst_b)
    smp && use_pin[1] |=> saddr_ff[6:4] == $past(pin_s[1].code[2:0]))
    else $error("high address bits not from pin");
  AST_ADDR_FLT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    smp && pin_s[0].flt |=> saddr_ff[3:0] == $past(daddr_ff[3:0]))
    else $error("floating low address not from stored value");
  AST_SAMPLE_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !smp |=> $stable(saddr_ff))
    else $error("address changed outside sampling");
  AST_IGNORE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    smp && gcfg_ff[GCFG_IGNORE] |=> $stable(freq_ff))
    else $error("frequency pin used while ignored");
  AST_BUSY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy_set |-> ##2 !alert_n)
    else $error("busy did not assert alert");
  AST_NOMASK_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pend |=> alert_n)
    else $error("alert low with nothing pending");
  AST_PLL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pll_ev |=> pll_ff)
    else $error("pll fault not recorded");
  AST_NOTA: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rd_go && avs_address == A_SWORD |=> avs_readdata[0] == |avs_readdata[15:12])
    else $error("upper nibble summary wrong");
endmodule : fac_top
`default_nettype wire

/* fac_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fac_top_tb;
  import fac_pkg::*;
  logic clk_sys, rst_b, ext_clk, ext_run, ext_flt, sync_o, sync_oe, alert_n;
  logic [7:0] adr;
  logic rd_s, wr_s, wait_s;
  logic [31:0] wd, rdat, q;
  fac_pin_s lo_p, hi_p, fq_p, v0_p, v1_p;
  fac_evt_s [1:0] evt;
  logic [1:0] fcond, fl_o, fl_oe, run, ss;
  logic [6:0] saddr;
  logic [3:0] fsel;
  logic [1:0][11:0] sp;
  fac_lim_s [1:0] lim;
  int bad_count, checks_done, cyc, ss_cnt;
  wire logic sync_w = sync_oe ? sync_o : ext_clk;
  wire logic [1:0] fl_w = {1'b1, ext_flt} & ~fl_oe;
  fac_host fac_host_i (.clk_sys(clk_sys), .avs_waitrequest(wait_s), .avs_readdata(rdat), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd));
  fac_top #(.MS_CYC(8)) fac_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wait_s),
    .addr_low_select_pin(lo_p), .addr_high_select_pin(hi_p), .freq_select_pin(fq_p),
    .ch0_voltage_select_pin(v0_p), .ch1_voltage_select_pin(v1_p), .ch_evt(evt), .fault_cond(fcond),
    .sync_i(sync_w), .sync_o(sync_o), .sync_oe(sync_oe), .fault_line_i(fl_w), .fault_line_o(fl_o),
    .fault_line_oe(fl_oe), .alert_n(alert_n), .slave_addr(saddr), .freq_sel(fsel), .ch_run(run),
    .ch_ss_start(ss), .ch_setpoint(sp), .ch_limits(lim));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Offset keeps link edges away from system clock edges
  initial begin
    ext_clk = 1'b0;
    #1;
    forever #40 ext_clk = ext_run ? ~ext_clk : 1'b0;
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic ev_pulse(input logic [6:0] e);
    evt[0] <= e;
    @(posedge clk_sys);
    evt <= '0;
    repeat (4) @(posedge clk_sys);
  endtask : ev_pulse
  always @(posedge clk_sys) begin
    cyc++;
    if (ss[0] === 1'b1) ss_cnt++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    rst_b = 1'b0;
    ext_run = 1'b0;
    ext_flt = 1'b1;
    evt = '0;
    fcond = 2'b00;
    lo_p = '{1'b0, 4'h5};
    hi_p = '{1'b1, 4'h0};
    fq_p = '{1'b0, 4'h3};
    v0_p = '{1'b0, 4'h2};
    v1_p = '{1'b1, 4'h0};
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("slave_addr", 32'(saddr), 32'h35);
    chk("ch_run", 32'(run), 32'h1);
    chk("setpoint0", 32'(sp[0]), 32'h140);
    chk("setpoint1", 32'(sp[1]), 32'(VOUT_RST));
    chk("ov_f", 32'(lim[0].ov_f), 32'h160);
    chk("ov_w", 32'(lim[0].ov_w), 32'h158);
    chk("vmax", 32'(lim[0].vmax), 32'h158);
    chk("mh", 32'(lim[0].mh), 32'h150);
    chk("ml", 32'(lim[0].ml), 32'h130);
    chk("uv_w", 32'(lim[0].uv_w), 32'h12b);
    chk("uv_f", 32'(lim[0].uv_f), 32'h129);
    chk("freq_sel", 32'(fsel), 32'h3);
    fq_p <= '{1'b0, 4'h7};
    repeat (6) @(posedge clk_sys);
    chk("freq_hold", 32'(fsel), 32'h3);
    fac_host_i.acc(1'b1, A_CMD, 32'h4, q);
    repeat (6) @(posedge clk_sys);
    chk("freq_restore", 32'(fsel), 32'h7);
    fac_host_i.acc(1'b0, A_PINS, 32'h0, q);
    chk("pins_isync", q & 32'h400, 32'h400);
    ev_pulse(7'h02);
    chk("alert_evt", 32'(alert_n), 32'h0);
    fac_host_i.acc(1'b0, A_STAT, 32'h0, q);
    chk("stat", q, 32'h2);
    fac_host_i.acc(1'b0, A_SWORD, 32'h0, q);
    chk("sword", q & 32'h8001, 32'h8001);
    fac_host_i.acc(1'b1, A_STAT, 32'h2, q);
    repeat (3) @(posedge clk_sys);
    chk("alert_w1c", 32'(alert_n), 32'h1);
    fac_host_i.acc(1'b1, A_MASK, 32'h2, q);
    ev_pulse(7'h02);
    chk("alert_mask", 32'(alert_n), 32'h1);
    fac_host_i.acc(1'b1, A_MASK, 32'hffff_ffff, q);
    fac_host_i.acc(1'b1, A_GCFG, 32'h10, q);
    repeat (3) @(posedge clk_sys);
    chk("alert_busy", 32'(alert_n), 32'h0);
    fac_host_i.acc(1'b0, A_GCFG, 32'h0, q);
    chk("gcfg_drop", q, 32'h0);
    fac_host_i.acc(1'b1, A_CMD, 32'h1, q);
    repeat (3) @(posedge clk_sys);
    chk("alert_clr", 32'(alert_n), 32'h1);
    fac_host_i.acc(1'b1, A_CTRL, 32'h0, q);
    fac_host_i.acc(1'b1, A_GCFG, 32'h10, q);
    ext_run <= 1'b1;
    repeat (60) @(posedge clk_sys);
    fac_host_i.acc(1'b0, A_PINS, 32'h0, q);
    chk("pins_ext", q & 32'h400, 32'h0);
    fac_host_i.acc(1'b0, A_COMMON, 32'h0, q);
    chk("ext_sync", q & 32'h8, 32'h8);
    fac_host_i.acc(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", q, 32'h0);
    ext_flt <= 1'b0;
    repeat (8) @(posedge clk_sys);
    fac_host_i.acc(1'b0, A_STAT, 32'h0, q);
    chk("ext_fault", q & 32'h20080, 32'h20080);
    chk("fl_oe", 32'(fl_oe), 32'h0);
    chk("fl_o", 32'(fl_o), 32'h0);
    ext_flt <= 1'b1;
    fac_host_i.acc(1'b1, A_FMAP, 32'h1, q);
    fac_host_i.acc(1'b1, A_CTRL, 32'h1, q);
    repeat (3) @(posedge clk_sys);
    chk("ss_start", 32'(ss_cnt), 32'h2);
    ev_pulse(7'h01);
    repeat (20) @(posedge clk_sys);
    chk("latch_run", 32'(run), 32'h0);
    chk("latch_fl_oe", 32'(fl_oe), 32'h1);
    fac_host_i.acc(1'b1, A_CTRL, 32'h0, q);
    fac_host_i.acc(1'b1, A_CTRL, 32'h1, q);
    fac_host_i.acc(1'b0, A_STAT, 32'h0, q);
    chk("offon_clear", q & 32'hff, 32'h0);
    fac_host_i.acc(1'b1, A_RESP, 32'h1, q);
    fcond <= 2'b01;
    ev_pulse(7'h01);
    // Fault still present at the first interval end, so no restart
    repeat (1700) @(posedge clk_sys);
    chk("retry_hold", 32'(run), 32'h0);
    chk("retry_fl_oe", 32'(fl_oe), 32'h1);
    fcond <= 2'b00;
    repeat (1700) @(posedge clk_sys);
    chk("retry_run", 32'(run), 32'h1);
    chk("retry_ss", 32'(ss_cnt), 32'h4);
    chk("retry_fl_rel", 32'(fl_oe), 32'h0);
    fac_host_i.acc(1'b1, A_CMD, 32'h1, q);
    fac_host_i.acc(1'b1, A_MASK, 32'h0, q);
    ev_pulse(7'h02);
    chk("alert_ara_pre", 32'(alert_n), 32'h0);
    fac_host_i.acc(1'b1, A_CMD, 32'h8, q);
    repeat (3) @(posedge clk_sys);
    chk("alert_ara", 32'(alert_n), 32'h1);
    fac_host_i.acc(1'b1, A_CTRL, 32'h0, q);
    fq_p <= '{1'b0, 4'h9};
    hi_p <= '{1'b0, 4'h2};
    ext_run <= 1'b0;
    fac_host_i.acc(1'b1, A_GCFG, 32'h40, q);
    fac_host_i.acc(1'b1, A_CMD, 32'h5, q);
    repeat (120) @(posedge clk_sys);
    chk("ign_freq", 32'(fsel), 32'h7);
    chk("ign_addr", 32'(saddr), 32'h25);
    q = 32'(sync_o);
    repeat (10) @(posedge clk_sys);
    chk("sync_o", 32'(sync_o), q ^ 32'h1);
    fac_host_i.acc(1'b1, A_FREQ, 32'h0, q);
    repeat (3) @(posedge clk_sys);
    chk("alert_pll", 32'(alert_n), 32'h0);
    fac_host_i.acc(1'b0, A_STAT, 32'h0, q);
    chk("stat_pll", q & 32'h10000, 32'h10000);
    fac_host_i.acc(1'b1, A_MASK, 32'h10000, q);
    fac_host_i.acc(1'b1, A_CMD, 32'h1, q);
    repeat (3) @(posedge clk_sys);
    chk("alert_pll_mask", 32'(alert_n), 32'h1);
    final_report();
  end
endmodule : fac_top_tb
`default_nettype wire
